// *** core/rcd_ctrl.sv ***
// How it works
// - internal reset comes from power-on, reset pin, low voltage, watchdog or cpu request.
// - the cause of each reset is latched in a readable cause flag register.
// - internal reset is released about 0.8 ms after the pin returns high.
// - after power-on, internal reset is released about 1.8 ms later.
// - watchdog or cpu request reset is released 30 clocks after it starts.
// - a warm reset returns the control registers to their reset values.
// - debug and flash security state is reset only by a cold reset.
// - after release the chip runs on the internal oscillator, pll and external off.
// - ram contents are not guaranteed after any reset.
// - source select bit 12 picks divided clock at 0, undivided clock at 1.
// - prescaler field 10-8 divides by 1 to 32, codes 110 and 111 reserved.
// - gear field 2-0 gives undivided or divide by 2 to 16, 001-011 reserved.
`timescale 1ns/1ps
module rcd_ctrl #(
  parameter int POR_REL_CYC = rcd_pkg::POR_REL_CYC,
  parameter int PIN_REL_CYC = rcd_pkg::PIN_REL_CYC
) (
  // clock and power-on reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // reset sources
  input  wire logic        I_RESET_PIN_N,
  input  wire logic        I_LOW_VOLT_DET,
  input  wire logic        I_WATCHDOG_RST,
  input  wire logic        I_CPU_SYSRST_REQ,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic             O_PREADY,
  output logic [31:0]      O_PRDATA,
  output logic             O_PSLVERR,
  // reset outputs
  output logic             O_SYS_RST_N,
  output logic             O_COLD_RST_N,
  // clock control
  output logic             O_EXT_OSC_SEL,
  output logic             O_PLL_ON,
  output logic             O_GEAR_CLK_EN,
  output logic             O_PERIPH_CLK_EN,
  output logic             O_PRESC_CLK_EN,
  // interrupt
  output logic             O_IRQ
);

  localparam int CW = rcd_pkg::CNT_W;
  localparam logic [CW-1:0] POR_LAST   = CW'(POR_REL_CYC - 1);
  localparam logic [CW-1:0] PIN_LAST   = CW'(PIN_REL_CYC - 1);
  localparam logic [CW-1:0] SHORT_LAST = CW'(rcd_pkg::SHORT_REL_CYC - 1);
  localparam logic [3:0]    PIN_MIN    = 4'(rcd_pkg::PIN_MIN_CYC);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // reset pin filter
  // ****************************************
  logic [3:0] pin_cnt_reg;
  logic       pin_low_reg;

  // short pin glitches never reach the sequencer
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt_reg <= 4'h0;
      pin_low_reg <= 1'b0;
    end else if (I_RESET_PIN_N) begin
      pin_cnt_reg <= 4'h0;
      pin_low_reg <= 1'b0;
    end else if (pin_cnt_reg != PIN_MIN) begin
      pin_cnt_reg <= pin_cnt_reg + 4'h1;
      pin_low_reg <= (pin_cnt_reg == PIN_MIN - 4'h1);
    end
  end

  // ****************************************
  // reset sequencer
  // ****************************************
  rcd_pkg::rcd_state_e state_reg;
  rcd_pkg::rcd_state_e state_next;
  logic [CW-1:0]       cnt_reg;
  logic [CW-1:0]       cnt_next;
  logic                hold;
  logic                soft_req;
  logic                cold_reg;
  logic                warm;

  assign hold     = pin_low_reg | I_LOW_VOLT_DET;
  assign soft_req = I_WATCHDOG_RST | I_CPU_SYSRST_REQ;
  assign warm     = (state_reg != rcd_pkg::ST_RUN);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    unique case (state_reg)
      rcd_pkg::ST_POR: begin
        // pin held low at power-up keeps the cold reset on, then releases after the pin release time instead of the power-on time
        if (hold) begin
          state_next = rcd_pkg::ST_HOLD;
          cnt_next   = '0;
        end else if (cnt_reg == POR_LAST) begin
          state_next = rcd_pkg::ST_RUN;
          cnt_next   = '0;
        end
      end
      rcd_pkg::ST_HOLD: begin
        cnt_next = '0;
        if (!hold) begin
          state_next = rcd_pkg::ST_PIN_REL;
        end
      end
      rcd_pkg::ST_PIN_REL: begin
        if (hold) begin
          state_next = rcd_pkg::ST_HOLD;
          cnt_next   = '0;
        end else if (cnt_reg == PIN_LAST) begin
          state_next = rcd_pkg::ST_RUN;
          cnt_next   = '0;
        end
      end
      rcd_pkg::ST_SHORT: begin
        if (hold) begin
          state_next = rcd_pkg::ST_HOLD;
          cnt_next   = '0;
        end else if (cnt_reg == SHORT_LAST) begin
          state_next = rcd_pkg::ST_RUN;
          cnt_next   = '0;
        end
      end
      rcd_pkg::ST_RUN: begin
        cnt_next = '0;
        if (hold) begin
          state_next = rcd_pkg::ST_HOLD;
        end else if (soft_req) begin
          state_next = rcd_pkg::ST_SHORT;
        end
      end
      default: begin
        state_next = rcd_pkg::ST_POR;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rcd_pkg::ST_POR;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // cold stays set from power-on until the first release only
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cold_reg     <= 1'b1;
      O_SYS_RST_N  <= 1'b0;
      O_COLD_RST_N <= 1'b0;
    end else begin
      if (state_next == rcd_pkg::ST_RUN) begin
        cold_reg <= 1'b0;
      end
      // no ram scrub on release, contents are whatever survived
      O_SYS_RST_N  <= (state_next == rcd_pkg::ST_RUN);
      O_COLD_RST_N <= !(cold_reg && state_next != rcd_pkg::ST_RUN);
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  logic        setup;
  logic        wr_fire;
  logic        hit;
  logic [31:0] rd_data;
  logic [31:0] sysctrl_reg;
  logic [31:0] osc_reg;
  logic [31:0] stby_reg;
  logic [31:0] pllsel_reg;
  logic [31:0] protect_reg;
  logic [4:0]  mask_reg;
  rcd_pkg::rcd_cause_s cause_reg;
  rcd_pkg::rcd_cause_s cause_set;
  rcd_pkg::rcd_cause_s cause_next;

  assign setup   = I_PSEL && !I_PENABLE;
  assign wr_fire = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;

  always_comb begin
    hit     = 1'b1;
    rd_data = 32'h0;
    unique case (I_PADDR)
      rcd_pkg::OFS_SYSCTRL:  rd_data = sysctrl_reg & rcd_pkg::SYSCTRL_MASK;
      rcd_pkg::OFS_OSCCTRL:  rd_data = osc_reg;
      rcd_pkg::OFS_STBYCTRL: rd_data = stby_reg;
      rcd_pkg::OFS_PLLSEL:   rd_data = pllsel_reg;
      rcd_pkg::OFS_PROTECT:  rd_data = protect_reg;
      rcd_pkg::OFS_CAUSE:    rd_data = {27'h0, cause_reg};
      rcd_pkg::OFS_IRQ_MASK: rd_data = {27'h0, mask_reg};
      default:               hit     = 1'b0;
    endcase
  end

  // zero wait states: answer in the first access cycle
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= setup;
      O_PRDATA  <= (setup && !I_PWRITE && hit) ? rd_data : 32'h0;
      O_PSLVERR <= setup && !hit;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // everything here is a warm-reset register
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sysctrl_reg <= rcd_pkg::SYSCTRL_RST;
      osc_reg     <= rcd_pkg::OSCCTRL_RST;
      stby_reg    <= rcd_pkg::STBYCTRL_RST;
      pllsel_reg  <= rcd_pkg::PLLSEL_RST;
      protect_reg <= rcd_pkg::PROTECT_RST;
      mask_reg    <= 5'h0;
    end else if (warm) begin
      sysctrl_reg <= rcd_pkg::SYSCTRL_RST;
      osc_reg     <= rcd_pkg::OSCCTRL_RST;
      stby_reg    <= rcd_pkg::STBYCTRL_RST;
      pllsel_reg  <= rcd_pkg::PLLSEL_RST;
      protect_reg <= rcd_pkg::PROTECT_RST;
      mask_reg    <= 5'h0;
    end else if (wr_fire) begin
      unique case (I_PADDR)
        rcd_pkg::OFS_SYSCTRL:  sysctrl_reg <= I_PWDATA & rcd_pkg::SYSCTRL_MASK;
        rcd_pkg::OFS_OSCCTRL:  osc_reg     <= I_PWDATA;
        rcd_pkg::OFS_STBYCTRL: stby_reg    <= I_PWDATA;
        rcd_pkg::OFS_PLLSEL:   pllsel_reg  <= I_PWDATA;
        rcd_pkg::OFS_PROTECT:  protect_reg <= I_PWDATA;
        rcd_pkg::OFS_IRQ_MASK: mask_reg    <= I_PWDATA[4:0];
        default:               mask_reg    <= mask_reg;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_EXT_OSC_SEL <= 1'b0;
      O_PLL_ON      <= 1'b0;
    end else begin
      O_EXT_OSC_SEL <= osc_reg[rcd_pkg::OSC_SEL_BIT];
      O_PLL_ON      <= osc_reg[rcd_pkg::PLL_ON_BIT];
    end
  end

  // ****************************************
  // cause flags and interrupt
  // ****************************************
  // flags survive warm resets so software can read the cause afterwards
  always_comb begin
    cause_set     = '0;
    cause_set.pin = pin_low_reg;
    cause_set.low_volt = I_LOW_VOLT_DET;
    cause_set.watchdog = I_WATCHDOG_RST;
    cause_set.cpu = I_CPU_SYSRST_REQ;
    cause_next    = cause_reg;
    if (wr_fire && I_PADDR == rcd_pkg::OFS_CAUSE) begin
      cause_next = cause_reg & ~I_PWDATA[4:0];
    end
    cause_next = cause_next | cause_set;
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= '{por: 1'b1, default: 1'b0};
      O_IRQ     <= 1'b0;
    end else begin
      cause_reg <= cause_next;
      O_IRQ     <= |(cause_next & mask_reg);
    end
  end

  // ****************************************
  // clock enables
  // ****************************************
  rcd_clk_en rcd_clk_en_inst (
    .clk         (I_CORE_CLK),
    .rst_n       (rst_n),
    .i_gear      (sysctrl_reg[rcd_pkg::GEAR_LSB +: 3]),
    .i_psrc_sel  (sysctrl_reg[rcd_pkg::PSRC_SEL_BIT]),
    .i_presc_sel (sysctrl_reg[rcd_pkg::PRESC_LSB +: 3]),
    .o_gear_en   (O_GEAR_CLK_EN),
    .o_periph_en (O_PERIPH_CLK_EN),
    .o_presc_en  (O_PRESC_CLK_EN)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!rst_n);

  chk_src_enter: assert property (
    state_reg == rcd_pkg::ST_RUN && (hold || soft_req) |=> !O_SYS_RST_N)
    else $error("reset source did not assert internal reset");

  chk_cause_watchdog: assert property (
    I_WATCHDOG_RST |=> cause_reg.watchdog)
    else $error("watchdog cause flag not set");

  chk_pin_release: assert property (
    $rose(O_SYS_RST_N) && $past(state_reg) == rcd_pkg::ST_PIN_REL
      |-> $past(cnt_reg) == PIN_LAST)
    else $error("pin release time wrong");

  chk_por_release: assert property (
    $rose(O_SYS_RST_N) && $past(state_reg) == rcd_pkg::ST_POR
      |-> $past(cnt_reg) == POR_LAST)
    else $error("power-on release time wrong");

  chk_short_len: assert property (
    state_reg == rcd_pkg::ST_RUN && !hold && soft_req
      |=> ##29 !O_SYS_RST_N ##1 O_SYS_RST_N)
    else $error("short reset not 30 cycles");

  chk_warm_only: assert property (
    $fell(O_SYS_RST_N) |-> O_COLD_RST_N)
    else $error("warm reset disturbed cold domain");

  chk_int_osc: assert property (
    $rose(O_SYS_RST_N) |-> !O_PLL_ON && !O_EXT_OSC_SEL)
    else $error("released without internal oscillator");

  chk_sysctrl_rsvd: assert property (
    O_PREADY && !I_PWRITE && I_PADDR == rcd_pkg::OFS_SYSCTRL
      |-> (O_PRDATA & ~rcd_pkg::SYSCTRL_MASK) == 32'h0)
    else $error("reserved system control bits read nonzero");

endmodule : rcd_ctrl

// *** core/rcd_pkg.sv ***
package rcd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] OFS_SYSCTRL   = 12'h000;
  localparam logic [11:0] OFS_OSCCTRL   = 12'h004;
  localparam logic [11:0] OFS_STBYCTRL  = 12'h008;
  localparam logic [11:0] OFS_PLLSEL    = 12'h00c;
  localparam logic [11:0] OFS_PROTECT   = 12'h03c;
  localparam logic [11:0] OFS_CAUSE     = 12'h010;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h014;

  localparam logic [31:0] SYSCTRL_RST   = 32'h0001_0000;
  localparam logic [31:0] SYSCTRL_MASK  = 32'h0003_1707;
  localparam logic [31:0] OSCCTRL_RST   = 32'h8001_0030;
  localparam logic [31:0] STBYCTRL_RST  = 32'h0000_0003;
  localparam logic [31:0] PLLSEL_RST    = 32'h0000_0000;
  localparam logic [31:0] PROTECT_RST   = 32'h0000_0000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int GEAR_LSB    = 0;
  localparam int PRESC_LSB   = 8;
  localparam int PSRC_SEL_BIT = 12;
  localparam int PLL_ON_BIT  = 2;
  localparam int OSC_SEL_BIT = 17;
  localparam int CAUSE_W     = 5;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_REL_NS    = 1_800_000;
  localparam int PIN_REL_NS    = 800_000;
  localparam int POR_REL_CYC   = POR_REL_NS / CLK_PERIOD_NS;
  localparam int PIN_REL_CYC   = PIN_REL_NS / CLK_PERIOD_NS;
  localparam int SHORT_REL_CYC = 30;
  localparam int PIN_MIN_CYC   = 12;
  localparam int CNT_W         = 15;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic low_volt;
    logic cpu;
    logic watchdog;
    logic pin;
    logic por;
  } rcd_cause_s;

  typedef enum logic [2:0] {
    ST_POR     = 3'b000,
    ST_HOLD    = 3'b001,
    ST_PIN_REL = 3'b010,
    ST_SHORT   = 3'b011,
    ST_RUN     = 3'b100
  } rcd_state_e;

endpackage : rcd_pkg

// *** core/rcd_clk_en.sv ***
`timescale 1ns/1ps
module rcd_clk_en (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // settings
  input  wire logic [2:0] i_gear,
  input  wire logic       i_psrc_sel,
  input  wire logic [2:0] i_presc_sel,
  // enables
  output logic            o_gear_en,
  output logic            o_periph_en,
  output logic            o_presc_en
);

  logic [3:0] gcnt_reg;
  logic [2:0] gsh_reg;
  logic       psrc_sel_reg;
  logic [4:0] pcnt_reg;
  logic [2:0] psh_reg;
  logic [2:0] gsh_new;
  logic [2:0] psh_new;
  logic       gwrap;
  logic       periph_tick;
  logic       pwrap;

  // reserved gear codes run undivided, reserved prescaler codes keep the old rate
  always_comb begin
    gsh_new = i_gear[2] ? (i_gear - 3'h3) : 3'h0;
    psh_new = (i_presc_sel > 3'h5) ? psh_reg : i_presc_sel;
  end

  assign gwrap       = (gcnt_reg == ((4'h1 << gsh_reg) - 4'h1));
  assign periph_tick = psrc_sel_reg | gwrap;
  assign pwrap       = periph_tick && (pcnt_reg == ((5'h1 << psh_reg) - 5'h1));

  // new settings load only at a period boundary, so no pulse is cut short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gcnt_reg  <= 4'h0;
      gsh_reg   <= 3'h0;
      psrc_sel_reg <= 1'b0;
    end else if (gwrap) begin
      gcnt_reg  <= 4'h0;
      gsh_reg   <= gsh_new;
      psrc_sel_reg <= i_psrc_sel;
    end else begin
      gcnt_reg  <= gcnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pcnt_reg <= 5'h0;
      psh_reg  <= 3'h0;
    end else if (pwrap) begin
      pcnt_reg <= 5'h0;
      psh_reg  <= psh_new;
    end else if (periph_tick) begin
      pcnt_reg <= pcnt_reg + 5'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      o_gear_en   <= 1'b0;
      o_periph_en <= 1'b0;
      o_presc_en  <= 1'b0;
    end else begin
      o_gear_en   <= gwrap;
      o_periph_en <= periph_tick;
      o_presc_en  <= pwrap;
    end
  end

  chk_gear_period: assert property (
    @(posedge clk) disable iff (!rst_n)
    o_gear_en && gsh_reg == 3'h2 |=> !o_gear_en [*3] ##1 o_gear_en)
    else $error("gear enable period wrong for divide by 4");

  chk_presc_direct: assert property (
    @(posedge clk) disable iff (!rst_n)
    o_presc_en && psh_reg == 3'h0 && psrc_sel_reg |=> o_presc_en)
    else $error("undivided prescaler on direct source missed a pulse");

endmodule : rcd_clk_en

// *** dv/rcd_pin_drv.sv ***
`timescale 1ns/1ps
// ******
// board reset pin driver
// ******
module rcd_pin_drv #(
  parameter int PWRUP_LOW_CYC = 10000
) (
  // clock
  input  wire logic        clk,
  // command
  input  wire logic        i_go,
  input  wire logic [15:0] i_low_cyc,
  // pin
  output logic             o_pin_n
);
  // pin held low from power-up until the regulator is settled
  logic [15:0] cnt_reg = 16'(PWRUP_LOW_CYC);
  logic        pin_reg = 1'b0;

  assign o_pin_n = pin_reg;

  always @(posedge clk) begin
    if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
      if (cnt_reg == 16'h0001) begin
        pin_reg <= 1'b1;
      end
    end else if (i_go) begin
      cnt_reg <= i_low_cyc;
      pin_reg <= 1'b0;
    end
  end
endmodule : rcd_pin_drv

// *** dv/rcd_ctrl_tb.sv ***
`timescale 1ns/1ps
module rcd_ctrl_tb;
  localparam int POR_C = 40;
  localparam int PIN_C = 20;
  logic        clk;
  logic        rst_n;
  logic        pin_go;
  logic [15:0] pin_low;
  logic        pin_n;
  logic        low_volt;
  logic        wdog;
  logic        cpu;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        sys_n;
  logic        cold_n;
  logic        ext_sel;
  logic        pll_on;
  logic [2:0]  en;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic        cold_low;
  int          bad_count;
  int          n_compared;

  rcd_ctrl #(.POR_REL_CYC(POR_C), .PIN_REL_CYC(PIN_C)) rcd_ctrl_inst (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_RESET_PIN_N(pin_n), .I_LOW_VOLT_DET(low_volt),
    .I_WATCHDOG_RST(wdog), .I_CPU_SYSRST_REQ(cpu), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_SYS_RST_N(sys_n),
    .O_COLD_RST_N(cold_n), .O_EXT_OSC_SEL(ext_sel), .O_PLL_ON(pll_on),
    .O_GEAR_CLK_EN(en[0]), .O_PERIPH_CLK_EN(en[1]), .O_PRESC_CLK_EN(en[2]),
    .O_IRQ(irq));

  rcd_pin_drv rcd_pin_drv_inst (.clk(clk), .i_go(pin_go), .i_low_cyc(pin_low),
    .o_pin_n(pin_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ******
  // shared tasks
  // ******
  task automatic give_verdict;
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic hang;
    check("wait_bound", 32'h0, 32'h1);
    give_verdict;
  endtask : hang

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask : rd_chk

  // counts sampled edges until the warm reset reaches level v
  task automatic wait_sys(input logic v, output int n);
    n = 0;
    while (sys_n !== v) begin
      @(posedge clk);
      n++;
      if (cold_n !== 1'b1) cold_low = 1'b1;
      if (n > 20000) hang;
    end
  endtask : wait_sys

  task automatic measure(input int sel, output int p);
    int i;
    i = 0;
    // a gear wrap at the write edge still loads the old setting, so skip it
    repeat (2) @(posedge clk);
    while (i < 2000 && en[0] !== 1'b1) begin
      @(posedge clk);
      i++;
    end
    while (i < 2000 && en[sel] !== 1'b1) begin
      @(posedge clk);
      i++;
    end
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (en[sel] !== 1'b1 && p < 2000);
    if (i == 2000 || p == 2000) hang;
  endtask : measure

  // ******
  // scenarios
  // ******
  task automatic t_powerup;
    int n;
    check("cold_in_pwrup", cold_n, 1'b0);
    for (n = 0; n < 20000 && pin_n !== 1'b1; n++) @(posedge clk);
    wait_sys(1'b1, n);
    check("pin_rel_win", 32'(n >= PIN_C && n <= PIN_C + 5), 32'h1);
    check("cold_rel", cold_n, 1'b1);
    rd_chk("cause_pwrup", 12'h010, 32'h0000_0003);
    rd_chk("sysctrl_rst", 12'h000, 32'h0001_0000);
    rd_chk("osc_rst", 12'h004, 32'h8001_0030);
    rd_chk("stby_rst", 12'h008, 32'h0000_0003);
    rd_chk("pllsel_rst", 12'h00c, 32'h0000_0000);
    rd_chk("protect_rst", 12'h03c, 32'h0000_0000);
    rd_chk("mask_rst", 12'h014, 32'h0000_0000);
    check("ext_osc_off", ext_sel, 1'b0);
    check("pll_off", pll_on, 1'b0);
    rd_chk("unmapped_rd", 12'h020, 32'h0);
    check("unmapped_err", er, 1'b1);
    apb(1'b1, 12'h000, 32'hffff_ffff);
    rd_chk("sysctrl_mask", 12'h000, 32'h0003_1707);
    // pll and external select on, so the next warm reset must clear them
    apb(1'b1, 12'h004, 32'h8003_0034);
    repeat (2) @(posedge clk);
    check("pll_on_set", pll_on, 1'b1);
    check("ext_osc_set", ext_sel, 1'b1);
  endtask : t_powerup

  task automatic t_clocks;
    int p;
    int k;
    logic [2:0] gc[6];
    int ge[6];
    gc = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1};
    ge = '{1, 2, 4, 8, 16, 1};
    for (k = 0; k < 6; k++) begin
      apb(1'b1, 12'h000, 32'h0001_0000 | 32'(gc[k]));
      measure(0, p);
      check("gear_period", p, ge[k]);
    end
    apb(1'b1, 12'h000, 32'h0001_1007);
    measure(1, p);
    check("periph_undiv", p, 1);
    for (k = 0; k < 7; k++) begin
      apb(1'b1, 12'h000, 32'h0001_1007 | (32'(k) << 8));
      measure(2, p);
      check("presc_period", p, 1 << ((k == 6) ? 5 : k));
    end
    apb(1'b1, 12'h000, 32'h0001_0004);
    measure(1, p);
    check("periph_gear", p, 2);
  endtask : t_clocks

  task automatic t_short(input logic c);
    int n;
    apb(1'b1, 12'h010, 32'h0000_001f);
    apb(1'b1, 12'h000, 32'h0001_0105);
    cold_low = 1'b0;
    @(posedge clk);
    cpu <= c;
    wdog <= ~c;
    @(posedge clk);
    cpu <= 1'b0;
    wdog <= 1'b0;
    wait_sys(1'b0, n);
    wait_sys(1'b1, n);
    check("short_len", n, 30);
    check("cold_kept", cold_low, 1'b0);
    rd_chk("warm_sysctrl", 12'h000, 32'h0001_0000);
    rd_chk("cause_short", 12'h010, c ? 32'h8 : 32'h4);
    check("pll_off_warm", pll_on, 1'b0);
    check("ext_off_warm", ext_sel, 1'b0);
  endtask : t_short

  task automatic t_irq;
    apb(1'b1, 12'h014, 32'h4);
    repeat (2) @(posedge clk);
    check("irq_set", irq, 1'b1);
    apb(1'b1, 12'h014, 32'h0);
    repeat (2) @(posedge clk);
    check("irq_masked", irq, 1'b0);
    apb(1'b1, 12'h014, 32'h4);
    apb(1'b1, 12'h010, 32'h4);
    repeat (2) @(posedge clk);
    check("irq_cleared", irq, 1'b0);
  endtask : t_irq

  task automatic t_long(input logic use_lv);
    int n1;
    int n2;
    apb(1'b1, 12'h010, 32'h0000_001f);
    cold_low = 1'b0;
    @(posedge clk);
    if (use_lv) low_volt <= 1'b1;
    else pin_go <= 1'b1;
    pin_low <= 16'h000c;
    @(posedge clk);
    pin_go <= 1'b0;
    repeat (4) @(posedge clk);
    low_volt <= 1'b0;
    for (n1 = 0; n1 < 100 && pin_n !== 1'b1; n1++) @(posedge clk);
    @(posedge clk);
    wait_sys(1'b0, n1);
    wait_sys(1'b1, n2);
    check("long_rel_win", 32'(n1 + n2 >= PIN_C && n1 + n2 <= PIN_C + 5), 32'h1);
    check("cold_kept", cold_low, 1'b0);
    rd_chk("cause_long", 12'h010, use_lv ? 32'h10 : 32'h2);
  endtask : t_long

  task automatic t_por;
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("cold_in_por", cold_n, 1'b0);
    rst_n <= 1'b1;
    wait_sys(1'b1, n);
    check("por_rel_win", 32'(n >= POR_C && n <= POR_C + 4), 32'h1);
    rd_chk("cause_por", 12'h010, 32'h0000_0001);
  endtask : t_por

  // ******
  // main sequence
  // ******
  initial begin
    bad_count  = 0;
    n_compared = 0;
    cold_low   = 1'b0;
    rst_n      = 1'b0;
    pin_go     = 1'b0;
    pin_low    = 16'h0000;
    low_volt   = 1'b0;
    wdog       = 1'b0;
    cpu        = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_powerup;
    t_clocks;
    t_short(1'b0);
    t_irq;
    t_short(1'b1);
    t_long(1'b0);
    t_long(1'b1);
    t_por;
    give_verdict;
  end
endmodule : rcd_ctrl_tb
